//--- logic/htg_pkg.sv
// constants and types shared by the host port tail tag block
//==============================================================================
// Contract
// - discarding port: tx 0, rx 0, learning off; carries and learns nothing (code still traps its IGMP and MLD frames to the host port)
// - flush of a port's table entries only while its learning is off
// - discarding port may still pass static override frames to host only
// - learning state learns addresses, forwards only to and from host
// - forwarding state forwards and receives normally, learning on
// - three-bit tree index picks one of eight trees, state held per tree
// - tag bytes sit after payload, just before the four FCS bytes
// - with tagging on, each frame to host gains one ingress tag byte
// - receive tag bit 7 set when a timestamp precedes the tag
// - receive tag bits 2:0 give ingress port minus one; 6:3 reserved
// - two-byte transmit tag is stripped before frames leave any port
// - transmit tag bit 10 set: bits 9:0 ignored, normal lookup used
// - transmit tag bit 9 set: selected ports send despite tx disable
// - with multiple queues, transmit tag bits 8:7 give priority 0 to 3
// - lookup clear: bits 6:0 are egress mask for ports 1 to 7
// - tag insertion and removal only on host port, others untagged
// - tagging off after reset; per-port tag enable bit makes host port
// - IGMP frames trapped and sent to host port only
// - MLD frames trapped and sent to host port only
// - programmed multicast groups go only to subscribed ports
package htg_pkg;
  //============================================================================
  // sizes
  localparam int NPORT   = 7;
  localparam int NTREE   = 8;
  localparam int ST_W    = 3;
  localparam int FCS_LEN = 4;
  localparam int TT_LEN  = 2;
  // per tree state field: tx enable, rx enable, learning disable
  localparam int ST_TX = 0;
  localparam int ST_RX = 1;
  localparam int ST_LD = 2;
  localparam logic [23:0] ST_RST = 24'h6DB6DB; // every tree forwarding
  //============================================================================
  // register map
  localparam logic [15:0] A_GCTRL  = 16'h0000;
  localparam logic [15:0] A_FLUSH  = 16'h0004;
  localparam logic [15:0] A_STAT   = 16'h0008;
  localparam logic [11:0] A_POPCTL = 12'h020; // port n at n in bits 15:12
  localparam logic [11:0] A_PSTP   = 12'h034;
  localparam int GC_MQ       = 0;
  localparam int POP_TAGEN   = 2;
  localparam int FL_TREE_LO  = 3;
  localparam int SA_REFUSED  = 4;
  localparam int HTRANS_ACT  = 1;
  //============================================================================
  // tag fields
  localparam int TT_LOOKUP = 10;
  localparam int TT_OVR    = 9;
  localparam int TT_PRIO   = 7;
  localparam int RT_PTP    = 7;
  typedef logic [NPORT-1:0] htg_pmask_t;
  typedef logic [NPORT-1:0][NTREE*ST_W-1:0] htg_stp_t;
endpackage

//--- logic/htg_stm_if.sv
// byte stream carrier between the block's own modules
interface htg_stm_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  logic       last;
  modport src (output data, output valid, output last, input ready);
  modport snk (input data, input valid, input last, output ready);
endinterface

//--- logic/htg_tag_ins.sv
// receive tag inserter on the frame stream toward the host
module htg_tag_ins (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_en,
  input  wire logic [2:0] i_port,
  input  wire logic       i_ptp,
  htg_stm_if.snk          s_in,
  htg_stm_if.src          s_out
);
  localparam int HOLD = htg_pkg::FCS_LEN;
  typedef enum logic [1:0] {FILL, TAG, DRAIN} htg_ins_st_t;
  typedef struct packed {
    htg_ins_st_t          st;
    logic [HOLD-1:0][7:0] hold;
    logic [2:0]           cnt;
    logic                 sof;
    logic [7:0]           tag;
  } htg_ins_t;
  htg_ins_t q;
  htg_ins_t d;

  //============================================================================
  // last four bytes held back so the tag lands before the FCS
  always_comb begin
    d = q;
    s_in.ready = 1'b0;
    s_out.valid = 1'b0;
    s_out.data = q.hold[0];
    s_out.last = 1'b0;
    case (q.st)
      FILL: begin
        s_in.ready = (q.cnt < 3'(HOLD)) || s_out.ready;
        s_out.valid = s_in.valid && (q.cnt == 3'(HOLD));
      end
      TAG: begin
        s_out.valid = 1'b1;
        s_out.data = q.tag;
        if (s_out.ready) d.st = DRAIN;
      end
      DRAIN: begin
        s_out.valid = q.cnt != 3'h0;
        s_out.last = q.cnt == 3'h1;
      end
      default: ;
    endcase
    if (s_out.valid && s_out.ready && q.st != TAG) begin
      d.hold = {8'h00, q.hold[HOLD-1:1]};
      d.cnt = q.cnt - 3'h1;
    end
    if (s_in.valid && s_in.ready) begin
      d.hold[d.cnt[1:0]] = s_in.data;
      d.cnt = d.cnt + 3'h1;
      d.sof = s_in.last;
      if (q.sof) d.tag = {i_ptp, 4'h0, i_port};
      if (s_in.last) d.st = i_en ? TAG : DRAIN;
    end
    if (q.st == DRAIN && d.cnt == 3'h0) d.st = FILL;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
      q.st <= FILL;
      q.sof <= 1'b1;
    end else begin
      q <= d;
    end
  end

  a_tag_format : assert property (
    @(posedge i_clk) disable iff (i_rst)
    (q.st == TAG && s_out.valid && s_out.ready)
    |-> s_out.data[6:3] == 4'h0 && s_out.data[2:0] != 3'h7 ##1 q.st == DRAIN)
    else $error("receive tag malformed or not followed by fcs");
endmodule // htg_tag_ins

//--- logic/htg_tag_strip.sv
// transmit tag stripper on the frame stream from the host
module htg_tag_strip (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_en,
  output logic [15:0]      o_tag,
  output logic             o_tag_vld,
  htg_stm_if.snk           s_in,
  htg_stm_if.src           s_out
);
  localparam int HOLD = htg_pkg::FCS_LEN + htg_pkg::TT_LEN;
  typedef enum logic [1:0] {FILL, DRAIN} htg_str_st_t;
  typedef struct packed {
    htg_str_st_t          st;
    logic [HOLD-1:0][7:0] hold;
    logic [2:0]           cnt;
    logic [15:0]          tag;
    logic                 tvld;
  } htg_str_t;
  htg_str_t q;
  htg_str_t d;

  assign o_tag = q.tag;
  assign o_tag_vld = q.tvld;

  //============================================================================
  // six bytes held back; at frame end the two tag bytes are taken out
  always_comb begin
    d = q;
    d.tvld = 1'b0;
    s_in.ready = 1'b0;
    s_out.valid = 1'b0;
    s_out.data = q.hold[0];
    s_out.last = 1'b0;
    case (q.st)
      FILL: begin
        s_in.ready = (q.cnt < 3'(HOLD)) || s_out.ready;
        s_out.valid = s_in.valid && (q.cnt == 3'(HOLD));
      end
      DRAIN: begin
        s_out.valid = q.cnt != 3'h0;
        s_out.last = q.cnt == 3'h1;
      end
      default: ;
    endcase
    if (s_out.valid && s_out.ready) begin
      d.hold = {8'h00, q.hold[HOLD-1:1]};
      d.cnt = q.cnt - 3'h1;
    end
    if (s_in.valid && s_in.ready) begin
      d.hold[d.cnt] = s_in.data;
      d.cnt = d.cnt + 3'h1;
      if (s_in.last) begin
        d.st = DRAIN;
        // tag is the two bytes ahead of the fcs
        if (i_en && d.cnt >= 3'(HOLD)) begin
          d.tag = {d.hold[0], d.hold[1]};
          d.hold = {16'h0000, d.hold[HOLD-1:2]};
          d.cnt = d.cnt - 3'h2;
          d.tvld = 1'b1;
        end
      end
    end
    if (q.st == DRAIN && d.cnt == 3'h0) d.st = FILL;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
      q.st <= FILL;
    end else begin
      q <= d;
    end
  end

  a_strip_fcs : assert property (
    @(posedge i_clk) disable iff (i_rst)
    $rose(q.tvld) |-> q.st == DRAIN && q.cnt <= 3'(htg_pkg::FCS_LEN))
    else $error("tag bytes left in the outgoing frame");
endmodule // htg_tag_strip

//--- logic/htg_top.sv
// host port tail tag framing and per-tree port state gating
module htg_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_fwd_valid,
  input  wire logic [2:0]  i_fwd_port,
  input  wire logic [2:0]  i_fwd_tree,
  input  wire logic [6:0]  i_fwd_mask,
  input  wire logic        i_fwd_static_ovr,
  input  wire logic        i_fwd_igmp,
  input  wire logic        i_fwd_mld,
  output logic             o_fwd_valid,
  output logic [6:0]       o_fwd_mask,
  output logic             o_fwd_learn,
  output logic             o_flush,
  output logic [2:0]       o_flush_port,
  output logic [2:0]       o_flush_tree,
  input  wire logic [7:0]  i_hrx_data,
  input  wire logic        i_hrx_valid,
  input  wire logic        i_hrx_last,
  input  wire logic [2:0]  i_hrx_port,
  input  wire logic        i_hrx_ptp,
  output logic             o_hrx_ready,
  output logic [7:0]       o_hmac_tx_data,
  output logic             o_hmac_tx_valid,
  output logic             o_hmac_tx_last,
  input  wire logic        i_hmac_tx_ready,
  input  wire logic [7:0]  i_hmac_rx_data,
  input  wire logic        i_hmac_rx_valid,
  input  wire logic        i_hmac_rx_last,
  output logic             o_hmac_rx_ready,
  output logic [7:0]       o_htx_data,
  output logic             o_htx_valid,
  output logic             o_htx_last,
  input  wire logic        i_htx_ready,
  input  wire logic [2:0]  i_htx_tree,
  output logic             o_htx_dec_valid,
  output logic [6:0]       o_htx_mask,
  output logic [1:0]       o_htx_prio,
  output logic             o_htx_lookup,
  output logic             o_htx_ovr
);
  typedef struct packed {
    logic                mq;
    htg_pkg::htg_pmask_t tag_en;
    htg_pkg::htg_stp_t   stp;
    logic                refused;
    logic                wr;
    logic                rd;
    logic                rd_done;
    logic [15:0]         addr;
    logic [31:0]         rdata;
    logic                fwd_vld;
    logic [6:0]          fwd_mask;
    logic                fwd_learn;
    logic                dec_vld;
    logic [6:0]          dec_mask;
    logic [1:0]          dec_prio;
    logic                dec_lookup;
    logic                dec_ovr;
    logic                flush;
    logic [2:0]          flush_port;
    logic [2:0]          flush_tree;
  } htg_top_t;
  htg_top_t q;
  htg_top_t d;

  //============================================================================
  // helpers
  function automatic logic [2:0] st_of(input htg_pkg::htg_stp_t s, input logic [2:0] p,
                                       input logic [2:0] t);
    st_of = s[p][int'(t) * htg_pkg::ST_W +: htg_pkg::ST_W];
  endfunction

  function automatic logic [6:0] txv_of(input htg_pkg::htg_stp_t s, input logic [2:0] t);
    for (int p = 0; p < htg_pkg::NPORT; p++) begin
      txv_of[p] = s[p][int'(t) * htg_pkg::ST_W + htg_pkg::ST_TX];
    end
  endfunction

  function automatic logic [6:0] onehot(input logic [2:0] p);
    onehot = 7'h01 << p;
  endfunction

  // lowest enabled port wins should software set more than one
  function automatic logic [3:0] host_of(input logic [6:0] en);
    host_of = 4'h0;
    for (int p = htg_pkg::NPORT - 1; p >= 0; p--) begin
      if (en[p]) host_of = {1'b1, 3'(p)};
    end
  endfunction

  function automatic logic is_preg(input logic [15:0] a, input logic [11:0] off);
    is_preg = !a[15] && a[14:12] != 3'h0 && a[11:0] == off;
  endfunction

  function automatic logic [2:0] pidx(input logic [15:0] a);
    pidx = a[14:12] - 3'h1;
  endfunction

  //============================================================================
  // derived state
  logic       hvld;
  logic [2:0] hidx;
  logic [6:0] hmask;
  logic [2:0] src_st;
  logic [6:0] src_oh;
  logic [6:0] fwd_txv;
  logic       from_host;
  logic [2:0] fl_p;
  logic [2:0] fl_t;
  logic [2:0] fl_st;
  logic [15:0] ttag;
  logic        tvld;
  logic [6:0]  m_fwd;
  logic [6:0]  m_dec;

  assign {hvld, hidx} = host_of(q.tag_en);
  assign hmask = hvld ? onehot(hidx) : 7'h00;
  assign src_st = st_of(q.stp, i_fwd_port, i_fwd_tree);
  assign src_oh = onehot(i_fwd_port);
  assign fwd_txv = txv_of(q.stp, i_fwd_tree);
  assign from_host = hvld && i_fwd_port == hidx;
  localparam int FL_TREE_END = htg_pkg::FL_TREE_LO + 2;
  assign fl_p = i_hwdata[2:0];
  assign fl_t = i_hwdata[FL_TREE_END:htg_pkg::FL_TREE_LO];
  assign fl_st = st_of(q.stp, fl_p, fl_t);

  //============================================================================
  // streams toward and from the host port
  htg_stm_if ins_in ();
  htg_stm_if ins_out ();
  htg_stm_if str_in ();
  htg_stm_if str_out ();

  assign ins_in.data = i_hrx_data;
  assign ins_in.valid = i_hrx_valid;
  assign ins_in.last = i_hrx_last;
  assign o_hrx_ready = ins_in.ready;
  assign o_hmac_tx_data = ins_out.data;
  assign o_hmac_tx_valid = ins_out.valid;
  assign o_hmac_tx_last = ins_out.last;
  assign ins_out.ready = i_hmac_tx_ready;
  assign str_in.data = i_hmac_rx_data;
  assign str_in.valid = i_hmac_rx_valid;
  assign str_in.last = i_hmac_rx_last;
  assign o_hmac_rx_ready = str_in.ready;
  assign o_htx_data = str_out.data;
  assign o_htx_valid = str_out.valid;
  assign o_htx_last = str_out.last;
  assign str_out.ready = i_htx_ready;

  // tagging only while some port is the host port
  htg_tag_ins u_ins (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_en   (hvld),
    .i_port (i_hrx_port),
    .i_ptp  (i_hrx_ptp),
    .s_in   (ins_in),
    .s_out  (ins_out)
  );

  htg_tag_strip u_strip (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_en      (hvld),
    .o_tag     (ttag),
    .o_tag_vld (tvld),
    .s_in      (str_in),
    .s_out     (str_out)
  );

  //============================================================================
  // outputs
  assign o_hrdata = q.rdata;
  assign o_hreadyout = !(q.rd && !q.rd_done);
  assign o_hresp = 1'b0;
  assign o_fwd_valid = q.fwd_vld;
  assign o_fwd_mask = q.fwd_mask;
  assign o_fwd_learn = q.fwd_learn;
  assign o_flush = q.flush;
  assign o_flush_port = q.flush_port;
  assign o_flush_tree = q.flush_tree;
  assign o_htx_dec_valid = q.dec_vld;
  assign o_htx_mask = q.dec_mask;
  assign o_htx_prio = q.dec_prio;
  assign o_htx_lookup = q.dec_lookup;
  assign o_htx_ovr = q.dec_ovr;

  //============================================================================
  // register bus, ingress gating and transmit tag decode
  always_comb begin
    d = q;
    d.flush = 1'b0;
    d.fwd_vld = 1'b0;
    d.dec_vld = 1'b0;
    m_fwd = 7'h00;
    m_dec = 7'h00;
    // read takes one wait cycle so a write just before it has landed
    if (q.rd && !q.rd_done) begin
      d.rd_done = 1'b1;
      d.rdata = 32'h0000_0000;
      if (q.addr == htg_pkg::A_GCTRL) d.rdata[htg_pkg::GC_MQ] = q.mq;
      else if (q.addr == htg_pkg::A_STAT) d.rdata[htg_pkg::SA_REFUSED:0] = {q.refused, hvld, hidx};
      else if (is_preg(q.addr, htg_pkg::A_POPCTL))
        d.rdata[htg_pkg::POP_TAGEN] = q.tag_en[pidx(q.addr)];
      else if (is_preg(q.addr, htg_pkg::A_PSTP)) d.rdata[23:0] = q.stp[pidx(q.addr)];
    end
    if (q.rd && q.rd_done) d.rd = 1'b0;
    if (q.wr) begin
      d.wr = 1'b0;
      if (q.addr == htg_pkg::A_GCTRL) d.mq = i_hwdata[htg_pkg::GC_MQ];
      else if (q.addr == htg_pkg::A_FLUSH) begin
        // flush only allowed while learning is off in that tree
        if (fl_p != 3'h7 && fl_st[htg_pkg::ST_LD]) begin
          d.flush = 1'b1;
          d.flush_port = fl_p;
          d.flush_tree = fl_t;
          d.refused = 1'b0;
        end else begin
          d.refused = 1'b1;
        end
      end
      else if (is_preg(q.addr, htg_pkg::A_POPCTL))
        d.tag_en[pidx(q.addr)] = i_hwdata[htg_pkg::POP_TAGEN];
      else if (is_preg(q.addr, htg_pkg::A_PSTP)) d.stp[pidx(q.addr)] = i_hwdata[23:0];
    end
    if (i_hsel && i_htrans[htg_pkg::HTRANS_ACT] && i_hready) begin
      d.addr = i_haddr[15:0];
      d.wr = i_hwrite;
      d.rd = !i_hwrite;
      d.rd_done = 1'b0;
    end
    // ingress forwarding gated by the source port state in its tree
    if (i_fwd_valid) begin
      m_fwd = i_fwd_mask & ~src_oh;
      if (i_fwd_igmp || i_fwd_mld) m_fwd = hmask & ~src_oh;
      else if (!from_host && !src_st[htg_pkg::ST_RX]) begin
        if (src_st[htg_pkg::ST_LD] && !i_fwd_static_ovr) m_fwd = 7'h00;
        else m_fwd = m_fwd & hmask;
      end
      m_fwd = m_fwd & (fwd_txv | hmask);
      if (i_fwd_port == 3'h7) m_fwd = 7'h00;
      d.fwd_vld = 1'b1;
      d.fwd_mask = m_fwd;
      d.fwd_learn = !src_st[htg_pkg::ST_LD] && i_fwd_port != 3'h7;
    end
    // host frame tag decode, reserved bits 15:11 never looked at
    if (tvld) begin
      d.dec_vld = 1'b1;
      if (ttag[htg_pkg::TT_LOOKUP]) begin
        d.dec_lookup = 1'b1;
        d.dec_ovr = 1'b0;
        d.dec_prio = 2'h0;
        d.dec_mask = 7'h00;
      end else begin
        m_dec = ttag[6:0] & ~hmask;
        if (!ttag[htg_pkg::TT_OVR]) m_dec = m_dec & txv_of(q.stp, i_htx_tree);
        d.dec_lookup = 1'b0;
        d.dec_ovr = ttag[htg_pkg::TT_OVR];
        d.dec_prio = q.mq ? ttag[htg_pkg::TT_PRIO +: 2] : 2'h0;
        d.dec_mask = m_dec;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
      q.stp <= {htg_pkg::NPORT{htg_pkg::ST_RST}};
    end else begin
      q <= d;
    end
  end

  //============================================================================
  // checks
  a_discard_drop : assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_fwd_valid && !from_host && !src_st[htg_pkg::ST_RX] && src_st[htg_pkg::ST_LD]
      && !i_fwd_static_ovr && !i_fwd_igmp && !i_fwd_mld
    |=> o_fwd_valid && o_fwd_mask == 7'h00 && !o_fwd_learn)
    else $error("discarding port forwarded or learned");

  a_discard_ovr : assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_fwd_valid && !from_host && !src_st[htg_pkg::ST_RX] && i_fwd_static_ovr
    |=> (o_fwd_mask & ~$past(hmask)) == 7'h00)
    else $error("override frame sent beyond the host port");

  a_learn_host : assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_fwd_valid && !from_host && !src_st[htg_pkg::ST_RX] && !src_st[htg_pkg::ST_LD]
      && i_fwd_port != 3'h7
    |=> o_fwd_learn && (o_fwd_mask & ~$past(hmask)) == 7'h00)
    else $error("learning port forwarded user traffic or did not learn");

  a_fwd_normal : assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_fwd_valid && !from_host && src_st == 3'h3 && !i_fwd_igmp && !i_fwd_mld
      && (fwd_txv | hmask) == 7'h7F && i_fwd_port != 3'h7
    |=> o_fwd_learn && o_fwd_mask == ($past(i_fwd_mask) & ~$past(src_oh)))
    else $error("forwarding port did not forward normally");

  a_trap_host : assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_fwd_valid && (i_fwd_igmp || i_fwd_mld) |=> (o_fwd_mask & ~$past(hmask)) == 7'h00)
    else $error("trapped group frame left a non host port");

  a_flush_gate : assert property (
    @(posedge i_clk) disable iff (i_rst)
    q.wr && q.addr == htg_pkg::A_FLUSH && !fl_st[htg_pkg::ST_LD] |=> !o_flush && q.refused)
    else $error("flush issued while learning enabled");

  a_lookup_ign : assert property (
    @(posedge i_clk) disable iff (i_rst)
    tvld && ttag[htg_pkg::TT_LOOKUP]
    |=> o_htx_dec_valid && o_htx_lookup && o_htx_mask == 7'h00 && !o_htx_ovr)
    else $error("lookup tag did not defer to normal forwarding");

  a_ovr_pass : assert property (
    @(posedge i_clk) disable iff (i_rst)
    tvld && !ttag[htg_pkg::TT_LOOKUP] && ttag[htg_pkg::TT_OVR]
    |=> o_htx_ovr && o_htx_mask == ($past(ttag[6:0]) & ~$past(hmask)))
    else $error("override tag did not bypass transmit blocking");

  a_prio_sel : assert property (
    @(posedge i_clk) disable iff (i_rst)
    tvld && !ttag[htg_pkg::TT_LOOKUP]
    |=> o_htx_prio == ($past(q.mq) ? $past(ttag[8:7]) : 2'h0))
    else $error("egress priority not taken from tag");

  a_tag_reset : assert property (
    @(posedge i_clk) disable iff (i_rst)
    $past(i_rst) |-> !hvld ##1 (!hvld || $past(q.wr)))
    else $error("tagging enabled out of reset");
endmodule // htg_top

//--- tb/htg_mac_model.sv
// host MAC model on the far side of the host port
module htg_mac_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_rx_last,
  input  wire logic       i_rx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  logic       slow = 1'h0;
  logic       tgl = 1'h0;
  //============================================================================
  // receive side: every cycle, or every other cycle when slow
  always @(posedge i_clk) begin
    tgl <= ~tgl;
    if (i_tx_valid && o_tx_ready) q.push_back(i_tx_data);
  end
  assign o_tx_ready = !slow || tgl;
  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'h0;
    o_rx_last = 1'h0;
  end
  // sends a frame; two tag bytes sit just before the four fcs bytes
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      o_rx_data <= f[i];
      o_rx_valid <= 1'h1;
      o_rx_last <= (i == f.size() - 1);
      @(posedge i_clk);
      while (!i_rx_ready) @(posedge i_clk);
    end
    o_rx_valid <= 1'h0;
    o_rx_last <= 1'h0;
    o_rx_data <= ~f[f.size() - 1]; // released line shows no stale byte
  endtask
endmodule // htg_mac_model

//--- tb/htg_tb_top.sv
// self-checking bench for the host port tail tag block
module host_port_tail_tag_and_stp_gating_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst = 1, hsel = 0, hwr = 0, fv = 0, fo = 0, fi = 0, fm = 0, hv = 0, hl = 0, hp = 0;
  logic [1:0] htr = 0;
  logic [2:0] fp = 0, ft = 0, hport = 0, flp, flt;
  logic [6:0] ofm, tm, fmk = 7'h7F;
  logic [7:0] hd = 0, mtd, mrd, td;
  logic [31:0] ha = 0, hw = 0, hr, hrdata;
  logic hro, ofv, ofl, hrxr, mtv, mtr, mrv, mrl, mrr, tv, tlk, tov, hrs, fls, tl, tdv, mtl;
  logic [1:0] tp;
  logic [7:0] hq[$];
  int error_cnt = 0, cmp_count = 0, cyc = 0, nfl = 0, nd = 0, nl = 0, nml = 0;
  htg_top dut (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(ha), .i_htrans(htr),
    .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hw), .i_hready(hro), .o_hrdata(hrdata),
    .o_hreadyout(hro), .o_hresp(hrs), .i_fwd_valid(fv), .i_fwd_port(fp), .i_fwd_tree(ft),
    .i_fwd_mask(fmk), .i_fwd_static_ovr(fo), .i_fwd_igmp(fi), .i_fwd_mld(fm),
    .o_fwd_valid(ofv), .o_fwd_mask(ofm), .o_fwd_learn(ofl), .o_flush(fls), .o_flush_port(flp),
    .o_flush_tree(flt), .i_hrx_data(hd), .i_hrx_valid(hv), .i_hrx_last(hl), .i_hrx_port(hport),
    .i_hrx_ptp(hp), .o_hrx_ready(hrxr), .o_hmac_tx_data(mtd), .o_hmac_tx_valid(mtv),
    .o_hmac_tx_last(mtl), .i_hmac_tx_ready(mtr), .i_hmac_rx_data(mrd), .i_hmac_rx_valid(mrv),
    .i_hmac_rx_last(mrl), .o_hmac_rx_ready(mrr), .o_htx_data(td), .o_htx_valid(tv),
    .o_htx_last(tl), .i_htx_ready(1'h1), .i_htx_tree(3'h0), .o_htx_dec_valid(tdv),
    .o_htx_mask(tm), .o_htx_prio(tp), .o_htx_lookup(tlk), .o_htx_ovr(tov));
  htg_mac_model mac (.i_clk(clk), .i_tx_data(mtd), .i_tx_valid(mtv), .o_tx_ready(mtr),
    .o_rx_data(mrd), .o_rx_valid(mrv), .o_rx_last(mrl), .i_rx_ready(mrr));
  //============================================================================
  // clock, stripped byte capture and hang guard
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (tv) hq.push_back(td);
    if (tv && tl) nl <= nl + 1;
    if (tdv) nd <= nd + 1;
    if (fls) nfl <= nfl + 1;
    if (mtv && mtr && mtl) nml <= nml + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    htr <= 2'h2;
    ha <= a;
    hwr <= w;
    @(posedge clk);
    while (!hro) @(posedge clk);
    hsel <= 0;
    htr <= 2'h0;
    hw <= d;
    @(posedge clk);
    while (!hro) @(posedge clk);
    hr = hrdata;
    cmp(32'(hrs), 32'h0);
  endtask
  //============================================================================
  // frame toward host: tag byte before fcs only once tagging is on
  task automatic rx(input logic tg);
    logic [7:0] s[$] = {8'h11, 8'h22, 8'h33, 8'hA1, 8'hA2, 8'hA3, 8'hA4};
    logic [7:0] e[$] = s;
    int m0 = nml;
    if (tg) e.insert(3, 8'h81);
    mac.q.delete();
    mac.slow = tg;
    foreach (s[i]) begin
      hd <= s[i];
      hv <= 1;
      hl <= (i == 6);
      hport <= 3'h1;
      hp <= 1;
      @(posedge clk);
      while (!hrxr) @(posedge clk);
    end
    hv <= 0;
    hd <= 8'h5A;
    repeat (30) @(posedge clk);
    cmp(32'(mac.q.size()), 32'(e.size()));
    cmp(32'(nml - m0), 32'h1);
    foreach (e[i]) cmp(32'(mac.q[i]), 32'(e[i]));
  endtask
  // frame from host: tag removed and decoded
  task automatic tx(input logic [15:0] t, input logic [10:0] e);
    int d0 = nd;
    int l0 = nl;
    hq.delete();
    mac.send({8'h55, 8'h66, t[15:8], t[7:0], 8'hF1, 8'hF2, 8'hF3, 8'hF4});
    repeat (20) @(posedge clk);
    cmp(32'(hq.size()), 32'h6);
    cmp({hq[0], hq[1], hq[2], hq[5]}, 32'h5566F1F4);
    cmp(32'({tm, tp, tlk, tov}), 32'(e));
    cmp(32'(nd - d0), 32'h1);
    cmp(32'(nl - l0), 32'h1);
  endtask
  // one forwarding request, checked one cycle later
  task automatic fwd(input logic [2:0] p, input logic [2:0] t, input logic [2:0] c,
                     input logic [7:0] e);
    fv <= 1;
    fp <= p;
    ft <= t;
    {fo, fi, fm} <= c;
    @(posedge clk);
    fv <= 0;
    @(posedge clk);
    cmp(32'({ofv, ofm, ofl}), 32'({1'h1, e}));
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  //============================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rx(0);
    ahb(1, 32'h1020, 32'h4); // port 1 becomes host, only one enable
    ahb(1, 32'h0, 32'h1);
    ahb(0, 32'h8, 32'h0);
    cmp(hr, 32'h8);
    ahb(0, 32'hF00, 32'h0);
    cmp(hr, 32'h0);
    rx(1);
    $display("tag insert test done");
    fmk <= 7'h5F;
    fwd(3'h3, 3'h0, 3'h0, 8'hAF);
    fmk <= 7'h7F;
    ahb(1, 32'h2034, 32'h4);
    ahb(1, 32'h3034, 32'h0);
    fwd(3'h1, 3'h0, 3'h0, 8'h00);
    fwd(3'h1, 3'h0, 3'h4, 8'h02);
    fwd(3'h1, 3'h1, 3'h0, 8'h03);
    fwd(3'h2, 3'h0, 3'h0, 8'h03);
    fwd(3'h3, 3'h0, 3'h0, 8'hE3);
    fwd(3'h3, 3'h0, 3'h2, 8'h03);
    fwd(3'h3, 3'h0, 3'h1, 8'h03);
    $display("gating test done");
    tx(16'h0015, 11'h100);
    tx(16'hFB85, 11'h04D);
    tx(16'h047D, 11'h002);
    $display("tag strip test done");
    ahb(1, 32'h4, 32'h1);
    ahb(0, 32'h8, 32'h0);
    cmp(hr, 32'h8);
    cmp(32'(flp), 32'h1);
    ahb(1, 32'h4, 32'h3);
    ahb(0, 32'h8, 32'h0);
    cmp(hr, 32'h18);
    cmp(32'(nfl), 32'h1);
    cmp(32'({flt, flp}), 32'h1);
    $display("flush test done");
    final_report;
  end
endmodule // host_port_tail_tag_and_stp_gating_tb_top
